//--- hw/gpb_pkg.sv
// Constants and helpers for the global parameter bank
// Summary of operation
// [R01] Eight-bit secondary address; zero disables it
// [R02] Read-only program counter of running program
// [R03] 32-bit millisecond tick counter, loadable by write
// [R04] Random read gives new value; write seeds
// [R05] Muted flag drops replies except read commands
// [R06] Mute flag volatile, cleared at every startup
// [R07] 256 user words; first 56 restored at boot
// [R08] Host sets interrupt parameters through bank three
// [R09] Lowest pending interrupt number served first
// [R10] Three timers interrupt every period milliseconds
// [R11] Two-bit trigger: off, rise, fall, both
// [R12] Six digital lines, each input or output
// [R13] Direction bit clear input, set output
// [R14] Bits 0-2 upper lines, 3-5 lower lines
// [R15] Direction vector resets to seven
// [R16] Switches and inputs synchronised before edge detection
package gpb_pkg;
  localparam logic [1:0] BANK_GLOBAL = 2'h0;
  localparam logic [1:0] BANK_USER = 2'h2;
  localparam logic [1:0] BANK_IRQ = 2'h3;
  localparam logic [7:0] OFS_TIMER0 = 8'h00;
  localparam logic [7:0] OFS_TIMER2 = 8'h02;
  localparam logic [7:0] OFS_LINE_DIR = 8'h4e;
  localparam logic [7:0] OFS_SEC_ADDR = 8'h57;
  localparam logic [7:0] OFS_RUN_STATE = 8'h80;
  localparam logic [7:0] OFS_LOADER = 8'h81;
  localparam logic [7:0] OFS_PROG_CNT = 8'h82;
  localparam logic [7:0] OFS_TICK = 8'h84;
  localparam logic [7:0] OFS_RANDOM = 8'h85;
  localparam logic [7:0] OFS_MUTE = 8'hff;
  // Edge source order: left stop, right stop, input 0..5
  localparam int EDGE_SRCS = 8;
  localparam logic [7:0] EDGE_OFS [EDGE_SRCS] = '{8'h1b, 8'h1c, 8'h27,
    8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c};
  // Pending order: timers 0..2 then edge sources, by rising number
  localparam int IRQ_SRCS = 11;
  localparam logic [7:0] IRQ_NUM [IRQ_SRCS] = '{8'h00, 8'h01, 8'h02,
    8'h1b, 8'h1c, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c};
  localparam logic [5:0] LINE_DIR_RST = 6'h07;
  localparam logic MUTE_RST = 1'b0;
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] USER_NV_WORDS = 8'h38;
  localparam logic [31:0] RANDOM_RST = 32'h00000001;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;

  // One step of a maximal 32-bit shift generator; zero is never kept
  function automatic logic [31:0] gpb_rnd_step(input logic [31:0] x);
    logic [31:0] y;
    y = (x == 32'h0) ? RANDOM_RST : x;
    return {y[30:0], y[31] ^ y[21] ^ y[1] ^ y[0]};
  endfunction
endpackage

//--- hw/gpb_umem.sv
// User variable memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module gpb_umem (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [31:0] wr_data,
  // Read port
  input wire logic [7:0] rd_addr,
  output logic [31:0] rd_data
);
  logic [31:0] mem [256];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // gpb_umem
`default_nettype wire

//--- hw/gpb_edge.sv
// Pin synchroniser with selectable edge detection
`timescale 1ns/1ps
`default_nettype none
module gpb_edge (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin and trigger selection
  input wire logic pin,
  input wire logic [1:0] sel,
  // Event pulse
  output logic evt
);
  import gpb_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic evt;
  } gpb_edge_s;

  gpb_edge_s s;
  gpb_edge_s n;
  logic rise;
  logic fall;

  always_comb begin
    n = s;
    rise = s.s2 & ~s.prev;
    fall = ~s.s2 & s.prev;
    n.s1 = pin;
    n.s2 = s.s1; // [R16]
    n.prev = s.s2;
    n.evt = (rise && sel[0]) || (fall && sel[1]); // [R11]
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign evt = s.evt;

  edge_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (sel == EDGE_OFF) |=> !evt) else $error("edge event while off"); // [R11]
endmodule // gpb_edge
`default_nettype wire

//--- hw/gpb_bank.sv
// Global, user variable and interrupt parameter bank
`timescale 1ns/1ps
`default_nettype none
module gpb_bank #(
  parameter int MS_CYC = gpb_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Parameter get/set requests
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [7:0] req_num,
  input wire logic [31:0] req_wdata,
  // Parameter answers
  output logic resp_valid,
  output logic resp_err,
  output logic [31:0] resp_rdata,
  // Program engine status
  input wire logic [1:0] run_state,
  input wire logic loader_mode,
  input wire logic [31:0] prog_counter,
  // Boot restore of saved user variables
  input wire logic nv_load_valid,
  input wire logic [7:0] nv_load_idx,
  input wire logic [31:0] nv_load_data,
  // Direct mode replies
  input wire logic dcmd_valid,
  input wire logic dcmd_exempt,
  output logic reply_go,
  // Secondary address
  output logic [7:0] sec_addr,
  output logic sec_addr_en,
  // Switch and input pins
  input wire logic stop_left,
  input wire logic stop_right,
  input wire logic [5:0] in_pins,
  // Interrupt requests
  output logic irq_valid,
  output logic [7:0] irq_num,
  input wire logic irq_ack,
  // Digital lines, upper 0..2 then lower 0..2
  input wire logic [5:0] line_out_req,
  output logic [5:0] line_o,
  output logic [5:0] line_oe
);
  import gpb_pkg::*;

  typedef struct packed {
    logic [2:0][31:0] per;
    logic [2:0][31:0] tcnt;
    logic [EDGE_SRCS-1:0][1:0] esel;
    logic [5:0] dir;
    logic [7:0] addr2;
    logic [31:0] pre;
    logic [31:0] tick;
    logic [31:0] rnd;
    logic mute;
    logic [IRQ_SRCS-1:0] pend;
    logic ivalid;
    logic [3:0] iidx;
    logic rv;
    logic rerr;
    logic rmem;
    logic [31:0] rdata;
    logic [5:0] lout;
    logic reply;
  } gpb_state_s;

  gpb_state_s s;
  gpb_state_s n;
  logic [EDGE_SRCS-1:0] evt;
  logic [EDGE_SRCS-1:0] epin;
  logic ms;
  logic mem_we;
  logic [7:0] mem_wa;
  logic [31:0] mem_wd;
  logic [31:0] mem_q;
  logic rd;
  logic wr;

  assign epin = {in_pins, stop_right, stop_left};

  genvar gi;
  generate
    for (gi = 0; gi < EDGE_SRCS; gi++) begin : g_edge
      gpb_edge u_edge (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin(epin[gi]),
        .sel(s.esel[gi]),
        .evt(evt[gi])
      );
    end
  endgenerate

  // Boot restore owns the write port; only saveable words are taken
  always_comb begin
    if (nv_load_valid) begin
      mem_we = (nv_load_idx < USER_NV_WORDS); // [R07]
      mem_wa = nv_load_idx;
      mem_wd = nv_load_data;
    end else begin
      mem_we = req_valid && req_write && (req_bank == BANK_USER);
      mem_wa = req_num;
      mem_wd = req_wdata;
    end
  end

  gpb_umem u_umem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(req_num),
    .rd_data(mem_q)
  );

  always_comb begin
    n = s;
    rd = req_valid && !req_write;
    wr = req_valid && req_write;
    n.rv = req_valid;
    n.rerr = 1'b0;
    n.rmem = 1'b0;
    n.rdata = 32'h0;
    n.lout = line_out_req;
    n.reply = dcmd_valid && (!s.mute || dcmd_exempt); // [R05]
    // Millisecond prescaler and tick counter
    ms = (s.pre == 32'(MS_CYC - 1));
    n.pre = ms ? 32'h0 : s.pre + 32'h1;
    if (ms) begin
      n.tick = s.tick + 32'h1; // [R03]
    end
    // Clear the presented request first so a new event wins
    if (irq_ack && s.ivalid) begin
      n.pend[s.iidx] = 1'b0;
    end
    for (int t = 0; t < 3; t++) begin
      if (ms && s.per[t] != 32'h0) begin
        if (s.tcnt[t] + 32'h1 >= s.per[t]) begin
          n.tcnt[t] = 32'h0;
          n.pend[t] = 1'b1; // [R10]
        end else begin
          n.tcnt[t] = s.tcnt[t] + 32'h1;
        end
      end
    end
    for (int e = 0; e < EDGE_SRCS; e++) begin
      if (evt[e]) begin
        n.pend[3 + e] = 1'b1; // [R11]
      end
    end
    // Parameter requests
    if (req_valid) begin
      unique case (req_bank)
        BANK_USER: begin
          n.rmem = rd; // [R07]
        end
        BANK_IRQ: begin
          n.rerr = 1'b1;
          if (req_num <= OFS_TIMER2) begin
            n.rerr = 1'b0;
            n.rdata = s.per[req_num[1:0]];
            if (wr) begin
              n.per[req_num[1:0]] = req_wdata; // [R08]
              n.tcnt[req_num[1:0]] = 32'h0;
            end
          end
          for (int e = 0; e < EDGE_SRCS; e++) begin
            if (req_num == EDGE_OFS[e]) begin
              n.rerr = 1'b0;
              n.rdata = {30'h0, s.esel[e]};
              if (wr) begin
                n.esel[e] = req_wdata[1:0]; // [R11]
              end
            end
          end
        end
        BANK_GLOBAL: begin
          unique case (req_num)
            OFS_LINE_DIR: begin
              n.rdata = {26'h0, s.dir};
              if (wr) begin
                n.dir = req_wdata[5:0]; // [R12]
              end
            end
            OFS_SEC_ADDR: begin
              n.rdata = {24'h0, s.addr2};
              if (wr) begin
                n.addr2 = req_wdata[7:0]; // [R01]
              end
            end
            OFS_RUN_STATE: begin
              n.rdata = {30'h0, run_state};
              n.rerr = wr;
            end
            OFS_LOADER: begin
              n.rdata = {31'h0, loader_mode};
              n.rerr = wr;
            end
            OFS_PROG_CNT: begin
              n.rdata = prog_counter; // [R02]
              n.rerr = wr;
            end
            OFS_TICK: begin
              n.rdata = s.tick;
              if (wr) begin
                n.tick = req_wdata; // [R03]
              end
            end
            OFS_RANDOM: begin
              if (wr) begin
                n.rnd = req_wdata; // [R04]
              end else begin
                n.rnd = gpb_rnd_step(s.rnd); // [R04]
                n.rdata = n.rnd;
              end
            end
            OFS_MUTE: begin
              n.rdata = {31'h0, s.mute};
              if (wr) begin
                n.mute = req_wdata[0]; // [R05]
              end
            end
            default: begin
              n.rerr = 1'b1;
            end
          endcase
        end
        default: begin
          n.rerr = 1'b1;
        end
      endcase
    end
    // Refused requests answer with zero data
    if (n.rerr) begin
      n.rdata = 32'h0;
    end
    // Lowest pending index carries the lowest interrupt number
    n.ivalid = 1'b0;
    n.iidx = 4'h0;
    for (int i = IRQ_SRCS - 1; i >= 0; i--) begin
      if (n.pend[i]) begin
        n.ivalid = 1'b1;
        n.iidx = 4'(i); // [R09]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.dir <= LINE_DIR_RST; // [R15]
      s.mute <= MUTE_RST; // [R06]
      s.rnd <= RANDOM_RST;
    end else begin
      s <= n;
    end
  end

  assign resp_valid = s.rv;
  assign resp_err = s.rerr;
  assign resp_rdata = s.rmem ? mem_q : s.rdata;
  assign reply_go = s.reply;
  assign sec_addr = s.addr2;
  assign sec_addr_en = (s.addr2 != 8'h0); // [R01]
  assign irq_valid = s.ivalid;
  assign irq_num = IRQ_NUM[s.iidx];
  assign line_o = s.lout;
  assign line_oe = s.dir; // [R13] [R14]

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic wr0;
  assign wr0 = wr && (req_bank == BANK_GLOBAL);

  addr_off_a: assert property (wr0 && req_num == OFS_SEC_ADDR && // [R01]
    req_wdata[7:0] == 8'h0 |=> !sec_addr_en)
    else $error("zero secondary address still enabled");
  pc_read_a: assert property (rd && req_bank == BANK_GLOBAL && // [R02]
    req_num == OFS_PROG_CNT |=> resp_rdata == $past(prog_counter))
    else $error("program counter read mismatch");
  tick_step_a: assert property (ms && !(wr0 && req_num == OFS_TICK) // [R03]
    |=> s.tick == $past(s.tick) + 32'h1)
    else $error("tick did not advance");
  rnd_new_a: assert property (rd && req_bank == BANK_GLOBAL && // [R04]
    req_num == OFS_RANDOM |=> resp_rdata != $past(s.rnd))
    else $error("random value repeated");
  reply_mute_a: assert property (dcmd_valid && s.mute && // [R05]
    !dcmd_exempt |=> !reply_go) else $error("reply not muted");
  reply_keep_a: assert property (dcmd_valid && dcmd_exempt // [R05]
    |=> reply_go) else $error("exempt reply dropped");
  irq_prio_a: assert property (irq_valid && s.pend[0] // [R09]
    |-> irq_num == 8'h00) else $error("timer 0 not served first");
  timer_fire_a: assert property (ms && s.per[0] == 32'h1 // [R10]
    |=> s.pend[0]) else $error("timer 0 missed period");
  dir_load_a: assert property (wr0 && req_num == OFS_LINE_DIR // [R13]
    |=> line_oe == $past(req_wdata[5:0]))
    else $error("direction vector not loaded");

  logic [IRQ_SRCS-1:0] pend_low;
  assign pend_low = s.pend & ((11'h1 << s.iidx) - 11'h1);

  ro_write_a: assert property (wr0 && req_num == OFS_PROG_CNT // [R02]
    |=> resp_err && resp_rdata == 32'h0)
    else $error("program counter write accepted");
  addr_load_a: assert property (wr0 && req_num == OFS_SEC_ADDR // [R01]
    |=> sec_addr == $past(req_wdata[7:0]))
    else $error("secondary address not loaded");
  tick_load_a: assert property (wr0 && req_num == OFS_TICK // [R03]
    |=> s.tick == $past(req_wdata))
    else $error("tick not loaded");
  rnd_seed_a: assert property (wr0 && req_num == OFS_RANDOM // [R04]
    |=> s.rnd == $past(req_wdata))
    else $error("seed not loaded");
  mute_load_a: assert property (wr0 && req_num == OFS_MUTE // [R05]
    |=> s.mute == $past(req_wdata[0]))
    else $error("mute flag not loaded");
  reply_idle_a: assert property (!dcmd_valid |=> !reply_go) // [R05]
    else $error("reply without command");
  nv_skip_a: assert property (nv_load_valid && // [R07]
    nv_load_idx >= USER_NV_WORDS |-> !mem_we)
    else $error("unsaved user word restored");
  bank_err_a: assert property (req_valid && req_bank == 2'h1 // [R08]
    |=> resp_valid && resp_err)
    else $error("unused bank accepted");
  irq_low_a: assert property (irq_valid |-> s.pend[s.iidx] && // [R09]
    pend_low == '0)
    else $error("lower interrupt left waiting");
  timer_off_a: assert property (s.per[0] == 32'h0 && !s.pend[0] // [R10]
    |=> !s.pend[0])
    else $error("disabled timer fired");
  edge_pend_a: assert property (evt[0] |=> s.pend[3]) // [R11]
    else $error("stop switch event lost");
  dir_hold_a: assert property (!(wr0 && req_num == OFS_LINE_DIR) // [R12]
    |=> $stable(line_oe))
    else $error("direction changed unasked");

  irq_seen_c: cover property (irq_valid && irq_ack);
  rnd_read_c: cover property (rd && req_num == OFS_RANDOM);
  mute_drop_c: cover property (dcmd_valid && s.mute && !dcmd_exempt);
  user_read_c: cover property (rd && req_bank == BANK_USER);
  timer_fire_c: cover property (ms && s.pend[0]);
endmodule // gpb_bank
`default_nettype wire

//--- sim/gpb_host.sv
// Host command interpreter model issuing parameter get/set requests
`timescale 1ns/1ps
`default_nettype none
module gpb_host (
  // Clock
  input wire logic ref_clk,
  // Requests
  output logic req_valid,
  output logic req_write,
  output logic [1:0] req_bank,
  output logic [7:0] req_num,
  output logic [31:0] req_wdata,
  // Answers
  input wire logic resp_valid,
  input wire logic resp_err,
  input wire logic [31:0] resp_rdata
);
  initial {req_valid, req_write, req_bank, req_num, req_wdata} = '0;

  // One request; the answer is taken half a cycle after the taking edge
  task xfer(input logic w, input logic [1:0] b, input logic [7:0] n,
      input logic [31:0] d, output logic [31:0] q, output logic e,
      output logic v);
    @(negedge ref_clk);
    {req_valid, req_write, req_bank, req_num, req_wdata} =
      {1'b1, w, b, n, d};
    @(negedge ref_clk);
    v = resp_valid;
    q = resp_rdata;
    e = resp_err;
    // Released lines except the bank no longer show the last value
    {req_valid, req_write, req_num, req_wdata} = {1'b0, ~w, ~n, ~d};
  endtask
endmodule // gpb_host
`default_nettype wire

//--- sim/tb_gpb_bank.sv
// Self-checking bench for the global parameter bank
`timescale 1ns/1ps
`default_nettype none
module tb_gpb_bank;
  import gpb_pkg::*;
  localparam int MSC = 5;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid, req_write, resp_valid, resp_err, re, rv;
  logic [1:0] req_bank, run_state;
  logic [7:0] req_num, nv_load_idx, sec_addr, irq_num, pins, ix;
  logic [31:0] req_wdata, resp_rdata, prog_counter, nv_load_data, rq, v;
  logic loader_mode, nv_load_valid, dcmd_valid, dcmd_exempt, reply_go;
  logic sec_addr_en, irq_valid, irq_ack;
  logic [5:0] line_out_req, line_o, line_oe;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  gpb_host gpb_host_inst (.ref_clk, .req_valid, .req_write, .req_bank,
    .req_num, .req_wdata, .resp_valid, .resp_err, .resp_rdata);
  gpb_bank #(.MS_CYC(MSC)) gpb_bank_inst (.ref_clk, .rst_n, .req_valid,
    .req_write, .req_bank, .req_num, .req_wdata, .resp_valid, .resp_err,
    .resp_rdata, .run_state, .loader_mode, .prog_counter, .nv_load_valid,
    .nv_load_idx, .nv_load_data, .dcmd_valid, .dcmd_exempt, .reply_go,
    .sec_addr, .sec_addr_en, .stop_left(pins[0]), .stop_right(pins[1]),
    .in_pins(pins[7:2]), .irq_valid, .irq_num, .irq_ack, .line_out_req,
    .line_o, .line_oe);

  always #25 ref_clk = ~ref_clk;

  task automatic end_of_test();
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic chk(input string s, input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", s, e, g);
      num_errors++;
    end
  endtask

  task automatic acc(input logic w, input logic [1:0] b,
      input logic [7:0] a, input logic [31:0] d, input logic ee);
    gpb_host_inst.xfer(w, b, a, d, rq, re, rv);
    chk("resp_valid", rv, 1);
    chk("resp_err", re, ee);
    if (ee)
      chk("err_rdata", rq, 0);
  endtask

  task automatic wirq(input int lim);
    n = 0;
    while (irq_valid !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic ack();
    irq_ack = 1'b1;
    @(negedge ref_clk);
    irq_ack = 1'b0;
  endtask

  task automatic dcmd(input logic ex);
    {dcmd_valid, dcmd_exempt} = {1'b1, ex};
    @(negedge ref_clk);
    dcmd_valid = 1'b0;
    rv = reply_go;
  endtask

  task automatic nvld(input logic [7:0] a, input logic [31:0] d);
    {nv_load_valid, nv_load_idx, nv_load_data} = {1'b1, a, d};
    @(negedge ref_clk);
    nv_load_valid = 1'b0;
    @(negedge ref_clk);
  endtask

  function automatic logic [31:0] rnx(input logic [31:0] x);
    logic [31:0] y;
    y = (x == 32'h0) ? 32'h1 : x;
    return {y[30:0], y[31] ^ y[21] ^ y[1] ^ y[0]};
  endfunction

  initial begin
    void'($urandom(32'hd64c5b1a));
    {run_state, loader_mode, prog_counter} = {2'h2, 1'b1, $urandom()};
    {nv_load_valid, nv_load_idx, nv_load_data, dcmd_valid} = '0;
    {dcmd_exempt, irq_ack, pins, line_out_req} = '0;
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("oe_rst", line_oe, 32'h7);
    acc(0, BANK_GLOBAL, OFS_MUTE, 0, 0);
    chk("mute_rst", rq, 0);
    // Status reads and refused accesses
    acc(0, BANK_GLOBAL, OFS_PROG_CNT, 0, 0);
    chk("prog_cnt", rq, prog_counter);
    acc(0, BANK_GLOBAL, OFS_RUN_STATE, 0, 0);
    chk("run_state", rq, 32'h2);
    acc(0, BANK_GLOBAL, OFS_LOADER, 0, 0);
    chk("loader", rq, 32'h1);
    acc(1, BANK_GLOBAL, OFS_RUN_STATE, 3, 1);
    acc(1, BANK_GLOBAL, OFS_PROG_CNT, 5, 1);
    acc(0, 2'h1, 8'h00, 0, 1);
    acc(1, BANK_IRQ, 8'h03, 1, 1);
    // Secondary address
    v = ($urandom % 255) + 1;
    acc(1, BANK_GLOBAL, OFS_SEC_ADDR, v, 0);
    chk("sec_addr", sec_addr, v);
    chk("sec_en", sec_addr_en, 1);
    acc(1, BANK_GLOBAL, OFS_SEC_ADDR, 0, 0);
    chk("sec_en", sec_addr_en, 0);
    // Direction vector and line levels
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      line_out_req = v[13:8];
      acc(1, BANK_GLOBAL, OFS_LINE_DIR, {26'h0, v[5:0]}, 0);
      chk("line_oe", line_oe, v[5:0]);
      chk("line_o", line_o, v[13:8]);
      acc(0, BANK_GLOBAL, OFS_LINE_DIR, 0, 0);
      chk("dir_rd", rq, v[5:0]);
    end
    // Tick counter load and count
    v = $urandom;
    acc(1, BANK_GLOBAL, OFS_TICK, v, 0);
    repeat (48) @(negedge ref_clk);
    acc(0, BANK_GLOBAL, OFS_TICK, 0, 0);
    chk("tick", (rq - v >= 9) && (rq - v <= 11), 1);
    // Random generator, zero seed first
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'h0 : $urandom;
      acc(1, BANK_GLOBAL, OFS_RANDOM, v, 0);
      repeat (2) begin
        v = rnx(v);
        acc(0, BANK_GLOBAL, OFS_RANDOM, 0, 0);
        chk("random", rq, v);
      end
    end
    // Reply suppression
    for (int i = 0; i < 4; i++) begin
      acc(1, BANK_GLOBAL, OFS_MUTE, i / 2, 0);
      dcmd(i % 2);
      chk("reply_go", rv, (i < 2) || (i % 2 == 1));
    end
    // User variables and boot restore at the 55/56 boundary
    for (int i = 0; i < 6; i++) begin
      ix = (i == 0) ? 8'hff : $urandom;
      v = $urandom;
      acc(1, BANK_USER, ix, v, 0);
      acc(0, BANK_USER, ix, 0, 0);
      chk("user", rq, v);
    end
    acc(1, BANK_USER, 8'h37, 32'h1111, 0);
    acc(1, BANK_USER, 8'h38, 32'h2222, 0);
    nvld(8'h37, 32'h5555);
    nvld(8'h38, 32'h6666);
    acc(0, BANK_USER, 8'h37, 0, 0);
    chk("nv_55", rq, 32'h5555);
    acc(0, BANK_USER, 8'h38, 0, 0);
    chk("nv_56", rq, 32'h2222);
    // Periodic timers
    for (int t = 0; t < 3; t++) begin
      acc(1, BANK_IRQ, t, t + 1, 0);
      wirq(40);
      chk("tmr_num", irq_num, t);
      ack();
      wirq(40);
      chk("tmr_gap", n + 1, (t + 1) * MSC);
      acc(1, BANK_IRQ, t, 0, 0);
      ack();
    end
    // Edge selection on every source and mode
    for (int s = 0; s < EDGE_SRCS; s++) begin
      for (int m = 0; m < 4; m++) begin
        acc(1, BANK_IRQ, EDGE_OFS[s], m, 0);
        for (int p = 0; p < 2; p++) begin
          pins[s] = !pins[s];
          wirq(10);
          chk("edge_irq", irq_valid, m[p]);
          if (irq_valid === 1'b1) begin
            chk("edge_num", irq_num, IRQ_NUM[s + 3]);
            ack();
          end
          repeat (3) @(negedge ref_clk);
          chk("edge_once", irq_valid, 0);
        end
      end
    end
    // Two sources at once: lowest number first
    pins[0] = 1'b1;
    pins[7] = 1'b1;
    wirq(10);
    @(negedge ref_clk);
    chk("prio_1", irq_num, IRQ_NUM[3]);
    ack();
    @(negedge ref_clk);
    chk("prio_2", irq_num, IRQ_NUM[10]);
    ack();
    // Second reset in mid-run
    acc(1, BANK_GLOBAL, OFS_MUTE, 1, 0);
    rst_n = 1'b0;
    @(negedge ref_clk);
    rst_n = 1'b1;
    acc(0, BANK_GLOBAL, OFS_MUTE, 0, 0);
    chk("mute_rst", rq, 0);
    chk("oe_rst", line_oe, 32'h7);
    end_of_test();
  end
endmodule // tb_gpb_bank
`default_nettype wire
